// ==== src/oled_seq_params.svh ====
// constants for the display controller reset and power sequencer
`ifndef OLED_SEQ_PARAMS_SVH
`define OLED_SEQ_PARAMS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_CONTRAST 4'h8
`define OFS_SCAN 4'hC
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_DISP_ON_BIT 0
`define CTRL_ENTIRE_ON_BIT 1
`define CTRL_MODE_BIT 2
`define CTRL_SEG_REMAP_BIT 3
`define CTRL_COM_REV_BIT 4
`define CTRL_SOFT_INIT_BIT 5
`define STAT_SHIFT_LSB 0
`define STAT_BITCNT_LSB 8
`define STAT_START_LSB 12
`define STAT_COL_LSB 20
// ----------------------------------------------------------------
// reset values, normal display code and panel size
// ----------------------------------------------------------------
`define RST_CONTRAST 8'h80
`define RST_START_LINE 6'h00
`define RST_COLUMN 8'h00
`define RST_SHIFT 8'h00
`define RST_BITCNT 3'h0
`define NORMAL_DISP_CODE 8'hA4
`define COLS_WIDE 132
`define ROWS_TALL 64
`endif

// ==== src/oled_seq_pkg.sv ====
// types shared by the display controller reset logic
package oled_seq_pkg;
  typedef enum logic {
    MODE_132X64,
    MODE_ALT
  } disp_mode_t;
  typedef enum logic [1:0] {
    ST_INIT,
    ST_IDLE,
    ST_ANSWER
  } bus_state_t;
endpackage : oled_seq_pkg

// ==== src/pin_sync.sv ====
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync width must be positive");
  end

  always_comb begin
    meta_nxt = ce_in ? async_in : meta_r;
    sync_nxt = ce_in ? meta_r : sync_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule : pin_sync

// ==== src/oled_power_reset_sequencer.sv ====
// display controller default state held by the hardware init pin
`timescale 1ns/1ps
`include "oled_seq_params.svh"

// Function
// RULE_01: host inserts settling delay between logic and panel supplies both ways.
// RULE_02: host powers logic, display off, init, clear, panel on, waits 100ms, on.
// RULE_03: host: display off, panel off, wait 100ms discharge, then logic off.
// RULE_04: while hw_init_n low, controller holds defaults with display off.
// RULE_05: init selects 132 by 64 addressing mode.
// RULE_06: init selects unmirrored mapping, first column and row at address zero.
// RULE_07: init clears serial shift register, dropping partial bits.
// RULE_08: init sets display start line to memory address zero.
// RULE_09: init clears column address counter to zero.
// RULE_10: init selects normal, non-reversed row driver scan direction.
// RULE_11: init loads contrast with 80h.
// RULE_12: init selects normal display mode, same as code A4h.
// RULE_13: host should reset and reinitialise display after noise corruption.
// RULE_14: host commands display off first when powering down.
// RULE_15: after init releases, defaults stay until host commands change them.
module oled_power_reset_sequencer
  import oled_seq_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic hw_init_n_in,
  input wire logic sclk_in,
  input wire logic sdin_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic display_on_out,
  output logic mode_132x64_out,
  output logic first_column_driver_remap_out,
  output logic row_drive_outputs_reversed_out,
  output logic [7:0] contrast_out,
  output logic [5:0] start_line_out,
  output logic [7:0] column_addr_out,
  output logic normal_display_out
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  pin_sync #(.WIDTH(3), .RESET_VAL(3'h0)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .async_in({hw_init_n_in, sclk_in, sdin_in}),
    .sync_out(pins_s)
  );
  logic init_act;
  logic sclk_s;
  logic sdin_s;
  assign init_act = ~pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdin_s = pins_s[0];

  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  logic disp_on_r, disp_on_nxt;
  logic entire_on_r, entire_on_nxt;
  disp_mode_t mode_r, mode_nxt;
  logic seg_remap_r, seg_remap_nxt;
  logic com_rev_r, com_rev_nxt;
  logic [7:0] contrast_r, contrast_nxt;
  logic [5:0] start_r, start_nxt;
  logic [7:0] col_r, col_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [2:0] bitcnt_r, bitcnt_nxt;
  logic sclk_d_r, sclk_d_nxt;
  bus_state_t bus_st_r, bus_st_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic soft_init;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction : merge

  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] ctrl_w;
  logic [31:0] scan_w;
  logic [31:0] cont_w;
  logic wr_take;
  logic rd_take;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`CTRL_DISP_ON_BIT] = disp_on_r;
    ctrl_word[`CTRL_ENTIRE_ON_BIT] = entire_on_r;
    ctrl_word[`CTRL_MODE_BIT] = (mode_r == MODE_ALT);
    ctrl_word[`CTRL_SEG_REMAP_BIT] = seg_remap_r;
    ctrl_word[`CTRL_COM_REV_BIT] = com_rev_r;
    status_word = 32'h0000_0000;
    status_word[`STAT_SHIFT_LSB +: 8] = shift_r;
    status_word[`STAT_BITCNT_LSB +: 3] = bitcnt_r;
    status_word[`STAT_START_LSB +: 6] = start_r;
    status_word[`STAT_COL_LSB +: 8] = col_r;
  end

  // ----------------------------------------------------------------
  // bus slave: one wait cycle, answer in the second
  // ----------------------------------------------------------------
  always_comb begin
    bus_st_nxt = bus_st_r;
    rdata_nxt = rdata_r;
    wr_take = 1'b0;
    rd_take = 1'b0;
    case (bus_st_r)
      ST_INIT: bus_st_nxt = ST_IDLE;
      ST_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          bus_st_nxt = ST_ANSWER;
          case (avs_address_in)
            `OFS_CTRL: rdata_nxt = ctrl_word;
            `OFS_STATUS: rdata_nxt = status_word;
            `OFS_CONTRAST: rdata_nxt = {24'h00_0000, contrast_r};
            `OFS_SCAN: rdata_nxt = {26'h000_0000, start_r};
            default: rdata_nxt = 32'h0000_0000;
          endcase
        end
      end
      ST_ANSWER: begin
        bus_st_nxt = ST_IDLE;
        wr_take = avs_write_in;
        rd_take = avs_read_in;
      end
      default: bus_st_nxt = ST_IDLE;
    endcase
  end
  assign avs_waitrequest_out = (bus_st_r != ST_ANSWER);
  assign avs_readdata_out = rdata_r;

  always_comb begin
    ctrl_w = merge(ctrl_word, avs_writedata_in, avs_byteenable_in);
    cont_w = merge({24'h00_0000, contrast_r}, avs_writedata_in, avs_byteenable_in);
    scan_w = merge({26'h000_0000, start_r}, avs_writedata_in, avs_byteenable_in);
  end
  assign soft_init = wr_take && (avs_address_in == `OFS_CTRL) && ctrl_w[`CTRL_SOFT_INIT_BIT];

  // ----------------------------------------------------------------
  // defaults under init, host changes otherwise
  // ----------------------------------------------------------------
  always_comb begin
    disp_on_nxt = disp_on_r;
    entire_on_nxt = entire_on_r;
    mode_nxt = mode_r;
    seg_remap_nxt = seg_remap_r;
    com_rev_nxt = com_rev_r;
    contrast_nxt = contrast_r;
    start_nxt = start_r;
    col_nxt = col_r;
    shift_nxt = shift_r;
    bitcnt_nxt = bitcnt_r;
    sclk_d_nxt = sclk_s;
    if (init_act || soft_init) begin
      disp_on_nxt = 1'b0; // see RULE_04
      mode_nxt = MODE_132X64; // see RULE_05
      seg_remap_nxt = 1'b0; // see RULE_06
      shift_nxt = `RST_SHIFT; // see RULE_07
      bitcnt_nxt = `RST_BITCNT; // see RULE_07
      start_nxt = `RST_START_LINE; // see RULE_08
      col_nxt = `RST_COLUMN; // see RULE_09
      com_rev_nxt = 1'b0; // see RULE_10
      contrast_nxt = `RST_CONTRAST; // see RULE_11
      entire_on_nxt = 1'b0; // see RULE_12
    end else begin
      // see RULE_15: only bus writes and serial data (shift, bit count, column) alter settings
      if (wr_take) begin
        case (avs_address_in)
          `OFS_CTRL: begin
            disp_on_nxt = ctrl_w[`CTRL_DISP_ON_BIT];
            entire_on_nxt = ctrl_w[`CTRL_ENTIRE_ON_BIT];
            mode_nxt = ctrl_w[`CTRL_MODE_BIT] ? MODE_ALT : MODE_132X64;
            seg_remap_nxt = ctrl_w[`CTRL_SEG_REMAP_BIT];
            com_rev_nxt = ctrl_w[`CTRL_COM_REV_BIT];
          end
          `OFS_CONTRAST: contrast_nxt = cont_w[7:0];
          `OFS_SCAN: start_nxt = scan_w[5:0];
          default: ;
        endcase
      end
      // serial data shifts in on rising sclk, msb first
      if (sclk_s && !sclk_d_r) begin
        shift_nxt = {shift_r[6:0], sdin_s};
        bitcnt_nxt = 3'(bitcnt_r + 3'h1);
        if (bitcnt_r == 3'h7) col_nxt = (col_r == 8'(`COLS_WIDE - 1)) ? 8'h00 : 8'(col_r + 8'h01);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      disp_on_r <= 1'b0;
      entire_on_r <= 1'b0;
      mode_r <= MODE_132X64;
      seg_remap_r <= 1'b0;
      com_rev_r <= 1'b0;
      contrast_r <= `RST_CONTRAST;
      start_r <= `RST_START_LINE;
      col_r <= `RST_COLUMN;
      shift_r <= `RST_SHIFT;
      bitcnt_r <= `RST_BITCNT;
      sclk_d_r <= 1'b0;
      bus_st_r <= ST_INIT;
      rdata_r <= 32'h0000_0000;
    end else if (ce_in) begin
      disp_on_r <= disp_on_nxt;
      entire_on_r <= entire_on_nxt;
      mode_r <= mode_nxt;
      seg_remap_r <= seg_remap_nxt;
      com_rev_r <= com_rev_nxt;
      contrast_r <= contrast_nxt;
      start_r <= start_nxt;
      col_r <= col_nxt;
      shift_r <= shift_nxt;
      bitcnt_r <= bitcnt_nxt;
      sclk_d_r <= sclk_d_nxt;
      bus_st_r <= bus_st_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign display_on_out = disp_on_r;
  assign mode_132x64_out = (mode_r == MODE_132X64);
  assign first_column_driver_remap_out = seg_remap_r;
  assign row_drive_outputs_reversed_out = com_rev_r;
  assign contrast_out = contrast_r;
  assign start_line_out = start_r;
  assign column_addr_out = col_r;
  assign normal_display_out = ~entire_on_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_init_disp_off: assert property (ce_in && init_act |=> !display_on_out) // see RULE_04
    else $error("display not off after init");
  a_init_mode: assert property (ce_in && init_act |=> mode_132x64_out && !first_column_driver_remap_out) // see RULE_05
    else $error("mode or mapping not default after init");
  a_init_shift: assert property (ce_in && init_act |=> shift_r == 8'h00 && bitcnt_r == 3'h0) // see RULE_07
    else $error("shift register not cleared");
  a_init_addr: assert property (ce_in && init_act |=> // see RULE_08
      start_line_out == 6'h00 && column_addr_out == 8'h00)
    else $error("start line or column not zero");
  a_init_scan: assert property (ce_in && init_act |=> !row_drive_outputs_reversed_out) // see RULE_10
    else $error("scan not normal after init");
  a_init_contrast: assert property (ce_in && init_act |=> contrast_out == 8'h80) // see RULE_11
    else $error("contrast not 80h after init");
  a_init_normal: assert property (ce_in && init_act |=> normal_display_out) // see RULE_12
    else $error("display mode not normal after init");
  a_hold_defaults: assert property (!init_act && !wr_take && ce_in |=> // see RULE_15
      $stable(contrast_out) && $stable(display_on_out) && $stable(start_line_out))
    else $error("setting changed without a write");
  a_bus_answer: assert property ((avs_read_in || avs_write_in) && bus_st_r == ST_IDLE && ce_in
      |=> !avs_waitrequest_out)
    else $error("bus answer late");

  c_init_seen: cover property (init_act ##1 !init_act);
  c_contrast_write: cover property (wr_take && avs_address_in == `OFS_CONTRAST);
  c_display_on: cover property (!display_on_out ##1 display_on_out);
  c_serial_byte: cover property (bitcnt_r == 3'h7 ##[1:50] bitcnt_r == 3'h0);
endmodule : oled_power_reset_sequencer

// ==== sim/host_model.sv ====
// host model driving the serial pins and the init pin
`timescale 1ns/1ps
module host_model (
  input wire logic clk_in,
  output logic sclk_out,
  output logic sdin_out,
  output logic hw_init_n_out
);
  logic in_frame;
  initial begin
    sclk_out = 1'b0;
    sdin_out = 1'b0;
    hw_init_n_out = 1'b1;
    in_frame = 1'b0;
  end
  // data line means nothing outside a frame
  always @(posedge clk_in) begin
    if (!in_frame) begin
      sdin_out <= ~sdin_out;
    end
  end
  // msb first, sclk high for hp cycles, low for hp+1 cycles between bits
  task automatic send_bits(input logic [7:0] b, input int n, input int hp);
    @(posedge clk_in);
    in_frame <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      sdin_out <= b[7-i];
      repeat (hp) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (hp) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (hp) @(posedge clk_in);
    in_frame <= 1'b0;
  endtask : send_bits
  // panel charge or discharge time, scaled down from the real delay
  localparam int SETTLE_CYCLES = 200;
  task automatic panel_settle;
    repeat (SETTLE_CYCLES) @(posedge clk_in);
  endtask : panel_settle
  // reset the display to recover from noise
  task automatic set_init(input logic v);
    @(posedge clk_in);
    hw_init_n_out <= v;
  endtask : set_init
endmodule : host_model

// ==== sim/oled_power_reset_sequencer_bench.sv ====
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
module oled_power_reset_sequencer_bench;
  import oled_seq_pkg::*;
  typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] r;} row_t;
  logic clk_in = 1'b0, rst_n_in = 1'b0, ce = 1'b1, sclk, sdin, hw_init_n;
  logic [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'hF;
  logic avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
  logic avs_waitrequest_out, display_on_out, mode_132x64_out, normal_display_out;
  logic first_column_driver_remap_out, row_drive_outputs_reversed_out;
  logic [7:0] contrast_out, column_addr_out;
  logic [5:0] start_line_out;
  int fails = 0, check_count = 0;
  row_t rows [4] = '{'{4'h0, 32'h1F, 32'h1F}, '{4'h8, 32'h3C, 32'h3C}, '{4'hC, 32'h15, 32'h15},
                     '{4'h2, 32'hFF, 32'h0}};
  always #25 clk_in = ~clk_in;
  host_model i_host_model (.clk_in(clk_in), .sclk_out(sclk), .sdin_out(sdin), .hw_init_n_out(hw_init_n));
  oled_power_reset_sequencer i_oled_power_reset_sequencer (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(ce), .hw_init_n_in(hw_init_n), .sclk_in(sclk), .sdin_in(sdin),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .display_on_out(display_on_out), .mode_132x64_out(mode_132x64_out),
    .first_column_driver_remap_out(first_column_driver_remap_out),
    .row_drive_outputs_reversed_out(row_drive_outputs_reversed_out), .contrast_out(contrast_out),
    .start_line_out(start_line_out), .column_addr_out(column_addr_out),
    .normal_display_out(normal_display_out));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge clk_in);
    // values seen here are those sampled at this edge; the watchdog ends a hang
    while (avs_waitrequest_out !== 1'b0) begin
      @(posedge clk_in);
    end
    r = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask : bus
  task automatic check_defaults;
    chk("display_on", 0, display_on_out);
    chk("mode_132x64", 1, mode_132x64_out);
    chk("column_remap", 0, first_column_driver_remap_out);
    chk("start_line", 0, start_line_out);
    chk("column_addr", 0, column_addr_out);
    chk("row_reverse", 0, row_drive_outputs_reversed_out);
    chk("contrast", 32'h80, contrast_out);
    chk("normal_display", 1, normal_display_out);
  endtask : check_defaults
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    check_defaults();
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, q);
      bus(1'b0, rows[i].a, 32'h0, q);
      chk("readback", rows[i].r, q);
    end
    chk("outputs", {1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h3C, 6'h15}, {display_on_out, mode_132x64_out,
        first_column_driver_remap_out, row_drive_outputs_reversed_out, normal_display_out,
        contrast_out, start_line_out});
    i_host_model.send_bits(8'hA5, 8, 4);
    bus(1'b0, 4'h4, 32'h0, q);
    chk("status_byte", 32'h0011_50A5, q);
    chk("column_addr", 1, column_addr_out);
    i_host_model.send_bits(8'hA5, 3, 3);
    bus(1'b0, 4'h4, 32'h0, q);
    chk("status_partial", 32'h0011_532D, q);
    i_host_model.set_init(1'b0);
    repeat (5) @(posedge clk_in);
    check_defaults();
    bus(1'b1, 4'h8, 32'h11, q);
    i_host_model.set_init(1'b1);
    repeat (4) @(posedge clk_in);
    bus(1'b0, 4'h4, 32'h0, q);
    chk("status_cleared", 32'h0, q);
    bus(1'b0, 4'h8, 32'h0, q);
    chk("contrast_kept", 32'h80, q);
    repeat (20) @(posedge clk_in);
    check_defaults();
    bus(1'b1, 4'h8, 32'h7E, q);
    chk("contrast_written", 32'h7E, contrast_out);
    // power down, then power up with a soft init
    bus(1'b1, 4'h0, 32'h00, q);
    chk("display_off", 0, display_on_out);
    i_host_model.panel_settle();
    bus(1'b1, 4'h0, 32'h00, q);
    bus(1'b1, 4'h0, 32'h20, q);
    check_defaults();
    i_host_model.panel_settle();
    bus(1'b1, 4'h0, 32'h01, q);
    chk("display_on", 1, display_on_out);
    // clock enable low freezes the init pin path
    ce <= 1'b0;
    i_host_model.set_init(1'b0);
    repeat (6) @(posedge clk_in);
    chk("frozen_display", 1, display_on_out);
    ce <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("display_off_init", 0, display_on_out);
    i_host_model.set_init(1'b1);
    repeat (4) @(posedge clk_in);
    stop_test();
  end
endmodule : oled_power_reset_sequencer_bench
